// ### hw/ams_top.sv
// Mode sequencer for the successive approximation converter.
`timescale 1ns/1ps

// Function
// R1 - Writing one to start flag begins conversion
// R2 - Writing zero to start flag stops conversion
// R3 - One-shot converts selected input once, stops
// R4 - Single modes clear flag at end, unless external
// R5 - Single modes raise interrupt at conversion end
// R6 - One-shot and repeat convert one selected channel
// R7 - Repeat converts continuously, never interrupts
// R8 - Result lands in converted channel's register
// R9 - Results readable anytime during repeating modes
// R10 - Single sweep converts each group channel once
// R11 - Sweep select picks first 2/4/6/8 channels
// R12 - Repeat sweep 0 loops group, no interrupt
// R13 - Repeat sweep 1 interleaves emphasis, no interrupt
// R14 - Sweep select picks 1/2/3/4 emphasis channels
// R15 - Sample and hold bit enables faster conversion
// R16 - Sample and hold takes 28 or 33 cycles
// R17 - Software fixes sample and hold before starting
// R18 - Trigger falling edge starts or restarts conversion
// R19 - Plain conversion takes 49 or 59 cycles
// R20 - Low byte even, top two bits odd
// R21 - Sweeps ascend from channel zero each start
// R22 - Stopping mid-conversion leaves result untouched
module ams_top (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic srst,
	// Software start flag write and configuration.
	input wire logic start_wr,
	input wire logic start_wdata,
	input wire ams_pkg::ams_cfg_s cfg,
	// Trigger pin and analog front end result.
	input wire logic ext_conv_trigger_in,
	input wire logic [9:0] sar_data,
	// Result read port.
	input wire logic [2:0] rd_chan,
	input wire logic rd_odd,
	output logic [7:0] rd_data,
	// Status.
	output logic start_flag,
	output logic conv_busy,
	output logic [2:0] conv_channel,
	output logic conv_irq
);
	import ams_pkg::*;

	ams_state_e state;
	ams_state_e next_state;
	ams_cfg_s cfg_l;
	ams_cfg_s next_cfg;
	ams_cfg_s cfg_src;
	ams_wr_s res_wr;
	logic [2:0] sync;
	logic [2:0] next_sync;
	logic trig_fall;
	logic sw_set;
	logic sw_clr;
	logic in_conv;
	logic launch;
	logic abort_now;
	logic good_done;
	logic final_done;
	logic single_mode;
	logic tmr_start;
	logic tmr_done;
	logic tmr_busy;
	logic [5:0] cyc_need;
	logic [2:0] last_chan;
	logic [2:0] emph_last;
	logic [2:0] other_first;
	logic [2:0] emph_idx;
	logic [2:0] other_idx;
	logic phase_emph;
	logic next_flag;
	logic next_busy;
	logic [2:0] next_chan;
	logic [2:0] next_emph;
	logic [2:0] next_other;
	logic next_phase;
	logic next_irq;

	////////////////////////////////////////////////////////////////////////
	// Trigger pin synchroniser; the edge detector looks only at later stages.
	always_comb begin
		next_sync = {sync[1:0], ext_conv_trigger_in};
	end

	// Registers only; idle level of the pin is high.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sync <= SYNC_RESET;
		end else begin
			sync <= next_sync;
		end
	end

	assign trig_fall = sync[2] && !sync[1];

	////////////////////////////////////////////////////////////////////////
	// Start, stop and conversion length decode.
	always_comb begin
		sw_set = start_wr && start_wdata;
		sw_clr = start_wr && !start_wdata;
		in_conv = (state == ST_CONV);
		// With the trigger selected a write of one only arms the converter.
		if (cfg.ext_trig_sel) begin
			launch = start_flag && !sw_clr && trig_fall; // R18
		end else begin
			launch = sw_set && !start_flag; // R1
		end
		abort_now = sw_clr && in_conv; // R22
		good_done = tmr_done && in_conv && !abort_now && !launch;
		// Length follows the config used by the conversion being started.
		cfg_src = launch ? cfg : cfg_l; // R17
		if (cfg_src.sh_enable) begin
			cyc_need = cfg_src.res_10bit ? CYC_10B_SH : CYC_8B_SH; // R15 R16
		end else begin
			cyc_need = cfg_src.res_10bit ? CYC_10B_PLAIN : CYC_8B_PLAIN; // R19
		end
		last_chan = {cfg_l.sweep_sel, 1'b1}; // R11
		emph_last = {1'b0, cfg_l.sweep_sel}; // R14
		other_first = {1'b0, cfg.sweep_sel} + 3'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Channel sequencing and end of conversion handling.
	always_comb begin
		next_state = state;
		next_cfg = cfg_l;
		next_chan = conv_channel;
		next_emph = emph_idx;
		next_other = other_idx;
		next_phase = phase_emph;
		final_done = 1'b0;
		single_mode = (cfg_l.mode == MODE_ONESHOT) || (cfg_l.mode == MODE_SSWEEP);
		if (launch) begin
			next_state = ST_CONV;
			next_cfg = cfg;
			next_emph = FIRST_CHAN;
			next_other = other_first;
			next_phase = 1'b1;
			if (cfg.mode == MODE_ONESHOT || cfg.mode == MODE_REPEAT) begin
				next_chan = cfg.chan_sel; // R6
			end else begin
				next_chan = FIRST_CHAN; // R21
			end
		end else if (abort_now) begin
			next_state = ST_IDLE; // R2
		end else if (good_done) begin
			case (cfg_l.mode)
				MODE_REPEAT: begin
					next_chan = cfg_l.chan_sel; // R7
				end
				MODE_SSWEEP: begin
					final_done = (conv_channel == last_chan); // R10
					next_chan = conv_channel + 3'h1; // R21
				end
				MODE_RSWEEP0: begin
					// Wrap to channel zero after the group's last channel.
					if (conv_channel == last_chan) begin
						next_chan = FIRST_CHAN; // R12
					end else begin
						next_chan = conv_channel + 3'h1;
					end
				end
				MODE_RSWEEP1: begin
					// Emphasis and remaining channels alternate slot by slot.
					if (phase_emph) begin
						next_chan = other_idx; // R13
						next_phase = 1'b0;
					end else begin
						next_other = (other_idx == LAST_CHAN) ? emph_last + 3'h1 : other_idx + 3'h1;
						next_emph = (emph_idx == emph_last) ? FIRST_CHAN : emph_idx + 3'h1;
						next_chan = next_emph; // R14
						next_phase = 1'b1;
					end
				end
				default: begin
					final_done = 1'b1; // R3
				end
			endcase
			if (final_done) begin
				next_state = ST_IDLE;
			end
		end
		tmr_start = launch || (good_done && !final_done);
		next_busy = (next_state == ST_CONV);
		// Interrupt only at the end of the single modes.
		next_irq = good_done && final_done && single_mode; // R5
		// Set by software wins over the hardware clear in the same cycle.
		next_flag = start_flag;
		if (good_done && final_done && !cfg_l.ext_trig_sel) begin
			next_flag = 1'b0; // R4
		end
		if (sw_clr) begin
			next_flag = 1'b0; // R2
		end
		if (sw_set) begin
			next_flag = 1'b1; // R1
		end
		// Results are written only for conversions that ran to the end.
		res_wr.valid = good_done; // R22
		res_wr.chan = conv_channel; // R8
		res_wr.data = cfg_l.res_10bit ? sar_data : {2'b00, sar_data[7:0]}; // R20
	end

	// Registers only.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= ST_IDLE;
			cfg_l <= '0;
			conv_channel <= FIRST_CHAN;
			emph_idx <= FIRST_CHAN;
			other_idx <= FIRST_CHAN;
			phase_emph <= 1'b0;
			start_flag <= 1'b0;
			conv_busy <= 1'b0;
			conv_irq <= 1'b0;
		end else begin
			state <= next_state;
			cfg_l <= next_cfg;
			conv_channel <= next_chan;
			emph_idx <= next_emph;
			other_idx <= next_other;
			phase_emph <= next_phase;
			start_flag <= next_flag;
			conv_busy <= next_busy;
			conv_irq <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion length counter and result bank.
	ams_conv_timer u_timer (
		.clk_sys(clk_sys),
		.srst(srst),
		.start(tmr_start),
		.abort(abort_now),
		.cycles(cyc_need),
		.done(tmr_done),
		.busy(tmr_busy)
	);

	ams_result_bank u_bank (
		.clk_sys(clk_sys),
		.srst(srst),
		.wr(res_wr),
		.rd_chan(rd_chan),
		.rd_odd(rd_odd),
		.rd_data(rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks. Helper counter measures each conversion from its start.
	logic [5:0] len_cnt;
	logic [5:0] len_need;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			len_cnt <= 6'h0;
			len_need <= 6'h0;
		end else if (tmr_start) begin
			len_cnt <= 6'h1;
			len_need <= cyc_need;
		end else if (tmr_busy) begin
			len_cnt <= len_cnt + 6'h1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence s_final_single;
		good_done && final_done && single_mode;
	endsequence

	sequence s_sweep_step;
		good_done && !final_done && (cfg_l.mode == MODE_SSWEEP || cfg_l.mode == MODE_RSWEEP0);
	endsequence

	a_sw_start_busy: assert property ( // R1
		sw_set && !start_flag && !cfg.ext_trig_sel |=> conv_busy ##1 tmr_busy)
		else $error("start write did not begin conversion");
	a_sw_stop_idle: assert property ( // R2
		sw_clr && !sw_set |=> !start_flag && !conv_busy)
		else $error("stop write did not halt conversion");
	a_oneshot_stop: assert property ( // R3
		good_done && cfg_l.mode == MODE_ONESHOT |=> !conv_busy)
		else $error("one-shot kept converting");
	a_flag_clear: assert property ( // R4
		s_final_single and (!cfg_l.ext_trig_sel && !start_wr) |=> !start_flag)
		else $error("flag not cleared at end");
	a_flag_kept_ext: assert property ( // R4
		s_final_single and (cfg_l.ext_trig_sel && !start_wr) |=> start_flag)
		else $error("flag lost with trigger");
	a_irq_at_end: assert property ( // R5
		s_final_single |=> conv_irq ##1 !conv_irq)
		else $error("interrupt not one pulse at end");
	a_irq_only_single: assert property ( // R7
		conv_irq |-> $past(single_mode) && $past(good_done))
		else $error("interrupt from repeating mode");
	a_oneshot_chan: assert property ( // R6
		conv_busy && (cfg_l.mode == MODE_ONESHOT || cfg_l.mode == MODE_REPEAT)
		|-> conv_channel == cfg_l.chan_sel)
		else $error("wrong channel selected");
	a_conv_length: assert property ( // R16
		tmr_done |-> len_cnt == len_need)
		else $error("conversion length wrong");
	a_sweep_order: assert property ( // R21
		s_sweep_step |=> conv_channel ==
		(($past(conv_channel) == last_chan) ? FIRST_CHAN : $past(conv_channel) + 3'h1))
		else $error("sweep order broken");
	a_rs1_emphasis: assert property ( // R13
		good_done && cfg_l.mode == MODE_RSWEEP1 && !phase_emph
		|=> (conv_channel <= emph_last) && phase_emph)
		else $error("emphasis slot skipped");
	a_trig_restart: assert property ( // R18
		cfg.ext_trig_sel && start_flag && !start_wr && trig_fall |=> conv_busy ##1 tmr_busy)
		else $error("trigger did not restart");
	a_abort_nowrite: assert property ( // R22
		sw_clr && in_conv |-> !res_wr.valid)
		else $error("aborted conversion wrote result");

endmodule

// ### include/ams_pkg.sv
// Shared types and constants for the converter mode sequencer.
package ams_pkg;

	////////////////////////////////////////////////////////////////////////
	// Channel and data geometry.
	localparam int NUM_CHAN = 8;
	localparam logic [2:0] FIRST_CHAN = 3'h0;
	localparam logic [2:0] LAST_CHAN = 3'h7;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [7:0] RD_RESET = 8'h00;
	localparam logic [2:0] SYNC_RESET = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// Conversion length per channel, in conversion clock cycles.
	localparam logic [5:0] CYC_8B_PLAIN = 6'h31; // 49 cycles, no sample and hold.
	localparam logic [5:0] CYC_10B_PLAIN = 6'h3b; // 59 cycles, no sample and hold.
	localparam logic [5:0] CYC_8B_SH = 6'h1c; // 28 cycles with sample and hold.
	localparam logic [5:0] CYC_10B_SH = 6'h21; // 33 cycles with sample and hold.

	////////////////////////////////////////////////////////////////////////
	// Operating modes.
	typedef enum logic [2:0] {
		MODE_ONESHOT = 3'h0,
		MODE_REPEAT = 3'h1,
		MODE_SSWEEP = 3'h2,
		MODE_RSWEEP0 = 3'h3,
		MODE_RSWEEP1 = 3'h4
	} ams_mode_e;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} ams_state_e;

	// Software configuration bits.
	typedef struct packed {
		ams_mode_e mode;
		logic [2:0] chan_sel;
		logic [1:0] sweep_sel;
		logic res_10bit;
		logic sh_enable;
		logic ext_trig_sel;
	} ams_cfg_s;

	// One result write into the per-channel bank.
	typedef struct packed {
		logic valid;
		logic [2:0] chan;
		logic [9:0] data;
	} ams_wr_s;

endpackage

// ### hw/ams_conv_timer.sv
// Per-channel conversion length counter.
`timescale 1ns/1ps
module ams_conv_timer (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic srst,
	// Control.
	input wire logic start,
	input wire logic abort,
	input wire logic [5:0] cycles,
	// Status.
	output logic done,
	output logic busy
);
	import ams_pkg::*;

	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic next_busy;

	////////////////////////////////////////////////////////////////////////
	// A start always reloads, so a back-to-back conversion loses no cycle.
	always_comb begin
		next_cnt = cnt;
		next_busy = busy;
		if (start) begin
			next_cnt = cycles - 6'h1;
			next_busy = 1'b1;
		end else if (abort) begin
			next_busy = 1'b0;
		end else if (busy && cnt == 6'h0) begin
			next_busy = 1'b0;
		end else if (busy) begin
			next_cnt = cnt - 6'h1;
		end
	end

	// Registers only.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt <= 6'h0;
			busy <= 1'b0;
		end else begin
			cnt <= next_cnt;
			busy <= next_busy;
		end
	end

	// Done marks the last cycle of the conversion.
	assign done = busy && (cnt == 6'h0);

endmodule

// ### hw/ams_result_bank.sv
// Per-channel result storage with a byte-wide read port.
`timescale 1ns/1ps
module ams_result_bank (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic srst,
	// Write side.
	input wire ams_pkg::ams_wr_s wr,
	// Read side.
	input wire logic [2:0] rd_chan,
	input wire logic rd_odd,
	output logic [7:0] rd_data
);
	import ams_pkg::*;

	logic [9:0] mem [NUM_CHAN];
	logic [9:0] next_mem [NUM_CHAN];
	logic [7:0] next_rd;

	////////////////////////////////////////////////////////////////////////
	// Reads never stall on writes, so results can be polled mid-conversion.
	always_comb begin
		next_mem = mem;
		if (wr.valid) begin
			next_mem[wr.chan] = wr.data; // R8
		end
		// Even byte holds the low eight bits, odd byte the top two.
		if (rd_odd) begin
			next_rd = {6'h00, mem[rd_chan][9:8]}; // R20
		end else begin
			next_rd = mem[rd_chan][7:0]; // R9
		end
	end

	// Registers only.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				mem[i] <= RESULT_RESET;
			end
			rd_data <= RD_RESET;
		end else begin
			mem <= next_mem;
			rd_data <= next_rd;
		end
	end

endmodule

// ### verification/tb_ams_top.sv
// Self-checking testbench for the converter mode sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_ams_top;
	import ams_pkg::*;
	logic clk_sys, srst, start_wr, start_wdata, ext_conv_trigger_in, rd_odd;
	logic start_flag, conv_busy, conv_irq, was_busy;
	ams_cfg_s cfg;
	logic [9:0] sar_data, s;
	logic [2:0] rd_chan, conv_channel, last_ch;
	logic [7:0] rd_data;
	logic [2:0] seq[$];
	int n_fail, cmp_count, busy_cyc, irq_cnt, n;

	ams_top uut (.clk_sys(clk_sys), .srst(srst), .start_wr(start_wr),
		.start_wdata(start_wdata), .cfg(cfg), .ext_conv_trigger_in(ext_conv_trigger_in),
		.sar_data(sar_data), .rd_chan(rd_chan), .rd_odd(rd_odd), .rd_data(rd_data),
		.start_flag(start_flag), .conv_busy(conv_busy), .conv_channel(conv_channel),
		.conv_irq(conv_irq));

	////////////////////////////////////////////////////////////////////////
	// Clock generator, 5 ns period.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// A distinct front-end value per channel, so a result in the wrong slot shows.
	function automatic logic [9:0] sar_of(input logic [2:0] ch);
		return {ch, ~ch, 4'h9};
	endfunction

	// The analog side answers for whatever channel is being converted.
	always @(posedge clk_sys) sar_data <= sar_of(conv_channel);

	// Monitor counts busy cycles and interrupts and logs each channel visit.
	always @(posedge clk_sys) begin
		if (conv_busy === 1'b1) busy_cyc++;
		if (conv_irq === 1'b1) irq_cnt++;
		if (conv_busy === 1'b1 && (conv_channel !== last_ch || was_busy !== 1'b1))
			seq.push_back(conv_channel);
		last_ch = conv_channel;
		was_busy = conv_busy;
	end

	////////////////////////////////////////////////////////////////////////
	// Access tasks.
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	task automatic sw_write(input logic v);
		start_wr <= 1'b1;
		start_wdata <= v;
		@(posedge clk_sys);
		start_wr <= 1'b0;
	endtask

	// Configure, clear the logs and write one to the start flag.
	task automatic go(input ams_mode_e m, input logic [2:0] ch, input logic [1:0] sw,
		input logic r, input logic sh, input logic ext);
		// Settings lead the start write by a cycle and then stay put for the run.
		cfg <= '{m, ch, sw, r, sh, ext};
		cyc(1);
		busy_cyc = 0;
		irq_cnt = 0;
		seq.delete();
		sw_write(1'b1);
		cyc(1);
	endtask

	// Bounded wait until busy reaches the given level.
	task automatic wait_for(input logic lvl, input int max);
		for (int i = 0; i < max && conv_busy !== lvl; i++) @(posedge clk_sys);
	endtask

	task automatic rd_chk(input logic [2:0] ch, input logic odd, input logic [7:0] e);
		rd_chan <= ch;
		rd_odd <= odd;
		cyc(2);
		`CHK("rd_data", e, rd_data)
	endtask

	// Packs the first k logged visits, one nibble each, padded with zero.
	function automatic logic [31:0] seq_word(input int k);
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < 8; i++) w = {w[27:0], (i < k) ? {1'b0, seq[i]} : 4'h0};
		return w;
	endfunction

	task automatic give_verdict();
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog; the whole sequence needs under two thousand cycles.
	initial begin
		cyc(20000);
		n_fail++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		srst = 1'b1;
		start_wr = 1'b0;
		start_wdata = 1'b0;
		ext_conv_trigger_in = 1'b1;
		cfg = '0;
		rd_chan = 3'h0;
		rd_odd = 1'b0;
		n_fail = 0;
		cmp_count = 0;
		cyc(4);
		srst <= 1'b0;
		cyc(4);
		`CHK("start_flag", 1'b0, start_flag)
		`CHK("conv_busy", 1'b0, conv_busy)
		// Stop in mid-conversion leaves the slot untouched and ends everything.
		go(MODE_ONESHOT, 3'h7, 2'h0, 1'b1, 1'b0, 1'b0);
		`CHK("conv_busy", 1'b1, conv_busy)
		cyc(20);
		sw_write(1'b0);
		cyc(1);
		`CHK("conv_busy", 1'b0, conv_busy)
		`CHK("start_flag", 1'b0, start_flag)
		cyc(70);
		rd_chk(3'h7, 1'b0, 8'h00);
		rd_chk(3'h7, 1'b1, 8'h00);
		// One-shot over all four length settings.
		for (int i = 0; i < 4; i++) begin
			n = i[0] ? (i[1] ? 33 : 28) : (i[1] ? 59 : 49);
			go(MODE_ONESHOT, 3'(i + 1), 2'h0, i[1], i[0], 1'b0);
			wait_for(1'b0, 80);
			cyc(2);
			s = sar_of(3'(i + 1));
			`CHK("length", n, busy_cyc)
			`CHK("irq_count", 1, irq_cnt)
			`CHK("start_flag", 1'b0, start_flag)
			`CHK("visits", 1, seq.size())
			`CHK("channel", 3'(i + 1), seq[0])
			rd_chk(3'(i + 1), 1'b0, s[7:0]);
			rd_chk(3'(i + 1), 1'b1, i[1] ? {6'h00, s[9:8]} : 8'h00);
		end
		// Single sweep over four channels.
		go(MODE_SSWEEP, 3'h0, 2'h1, 1'b1, 1'b1, 1'b0);
		wait_for(1'b0, 200);
		cyc(2);
		`CHK("length", 4 * 33, busy_cyc)
		`CHK("order", 32'h01230000, seq_word(4))
		`CHK("visits", 4, seq.size())
		`CHK("irq_count", 1, irq_cnt)
		`CHK("start_flag", 1'b0, start_flag)
		for (int c = 0; c < 4; c++) begin
			s = sar_of(3'(c));
			rd_chk(3'(c), 1'b1, {6'h00, s[9:8]});
		end
		// Repeat mode, read while running, then stop.
		go(MODE_REPEAT, 3'h5, 2'h0, 1'b0, 1'b1, 1'b0);
		cyc(90);
		s = sar_of(3'h5);
		rd_chk(3'h5, 1'b0, s[7:0]);
		`CHK("conv_busy", 1'b1, conv_busy)
		`CHK("channel", 3'h5, conv_channel)
		sw_write(1'b0);
		cyc(1);
		`CHK("conv_busy", 1'b0, conv_busy)
		`CHK("irq_count", 0, irq_cnt)
		// Repeat sweep 0 on two channels.
		go(MODE_RSWEEP0, 3'h0, 2'h0, 1'b0, 1'b1, 1'b0);
		cyc(240);
		sw_write(1'b0);
		`CHK("order", 32'h01010101, seq_word(8))
		`CHK("irq_count", 0, irq_cnt)
		// Repeat sweep 1 with one and with two emphasised channels.
		for (int e = 0; e < 2; e++) begin
			go(MODE_RSWEEP1, 3'h0, 2'(e), 1'b0, 1'b1, 1'b0);
			cyc(240);
			sw_write(1'b0);
			`CHK("order", e ? 32'h02130415 : 32'h01020304, seq_word(8))
			`CHK("irq_count", 0, irq_cnt)
		end
		// External trigger: arm, fire, flag stays, fire again.
		cyc(4);
		go(MODE_ONESHOT, 3'h2, 2'h0, 1'b0, 1'b1, 1'b1);
		cyc(10);
		`CHK("conv_busy", 1'b0, conv_busy)
		ext_conv_trigger_in <= 1'b0;
		wait_for(1'b1, 10);
		`CHK("conv_busy", 1'b1, conv_busy)
		wait_for(1'b0, 40);
		cyc(2);
		`CHK("start_flag", 1'b1, start_flag)
		`CHK("irq_count", 1, irq_cnt)
		ext_conv_trigger_in <= 1'b1;
		cyc(6);
		ext_conv_trigger_in <= 1'b0;
		wait_for(1'b1, 10);
		`CHK("conv_busy", 1'b1, conv_busy)
		sw_write(1'b0);
		cyc(1);
		`CHK("start_flag", 1'b0, start_flag)
		give_verdict();
	end
endmodule
